// ### include/opt_pkg.sv
package opt_pkg;
  localparam int          OPT_ADDR_W      = 8;
  localparam int          OPT_DATA_W      = 32;
  // register byte address: printed offset 0x0F is not a multiple of four
  localparam logic [7:0]  OPT_REG_IDX     = 8'h0F;
  localparam logic [7:0]  OPT_REG_ADDR    = 8'h3C;
  // status register of our own: variant strap readback and irq status
  localparam logic [7:0]  OPT_STAT_ADDR   = 8'h40;
  localparam int          OPT_WDOG_BIT    = 1;
  localparam int          OPT_SENS_BIT    = 0;
  localparam int          OPT_STAT_PEND   = 0;
  localparam int          OPT_STAT_PIN    = 1;
  localparam int          OPT_STAT_LOCK   = 2;
  localparam int          OPT_STAT_MASK   = 3;
  localparam logic [31:0] OPT_ZERO        = 32'h0000_0000;
  localparam logic        OPT_WDOG_RST    = 1'b0;
  localparam logic        OPT_SENS_RST    = 1'b0;
endpackage

// ### verilog/opt_regs.sv
// Local design decision: register access over Wishbone.
module opt_regs
  import opt_pkg::*;
#(
  parameter logic MASK_VARIANT   = 1'b0,
  parameter logic MASK_WDOG_EN   = 1'b1,
  parameter logic MASK_HALT_EN   = 1'b1
)
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  arst_n_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [OPT_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [OPT_DATA_W-1:0] wb_dat_i,
  output logic      [OPT_DATA_W-1:0] wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  input  wire logic                  irq_n_i,
  input  wire logic                  irq_ack_i,
  output logic                       irq_req_o,
  output logic                       wdog_en_o,
  output logic                       halt_en_o
);

  typedef enum logic [1:0]
  {
    OPT_IDLE = 2'b01,
    OPT_RESP = 2'b10
  } opt_bus_e;

  opt_bus_e state;
  opt_bus_e next_state;
  logic     watchdog_disable_bit;
  logic     next_watchdog_disable_bit;
  logic     sens;
  logic     next_sens;
  logic     locked;
  logic     next_locked;
  logic     pend;
  logic     next_pend;
  logic     irq_q;
  logic     next_irq_q;
  logic [OPT_DATA_W-1:0] next_dat;
  logic     next_ack;
  logic     next_err;

  function automatic logic hit(input logic [OPT_ADDR_W-1:0] a);
    return (a == OPT_REG_ADDR) || (a == OPT_STAT_ADDR);
  endfunction

  logic req;
  logic wr_opt;
  logic fall;

  // ack drops the cycle after it was given, so one request gives one pulse
  assign req    = wb_cyc_i && wb_stb_i && (state == OPT_IDLE);
  assign wr_opt = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == OPT_REG_ADDR);
  assign fall   = irq_q && !irq_n_i;

  always_comb
  begin
    next_state                = state;
    next_dat                  = OPT_ZERO;
    next_ack                  = 1'b0;
    next_err                  = 1'b0;
    next_watchdog_disable_bit = watchdog_disable_bit;
    next_sens                 = sens;
    next_locked               = locked;
    unique case (state)
      OPT_IDLE:
      begin
        if (req)
        begin
          next_state = OPT_RESP;
          next_ack   = hit(wb_adr_i);
          next_err   = !hit(wb_adr_i);
          if (wb_adr_i == OPT_REG_ADDR)
          begin
            next_dat[OPT_WDOG_BIT] = watchdog_disable_bit;
            next_dat[OPT_SENS_BIT] = sens;
          end
          else if (wb_adr_i == OPT_STAT_ADDR)
          begin
            next_dat[OPT_STAT_PEND] = pend;
            next_dat[OPT_STAT_PIN]  = irq_n_i;
            next_dat[OPT_STAT_LOCK] = locked;
            next_dat[OPT_STAT_MASK] = MASK_VARIANT;
          end
        end
      end
      OPT_RESP:
      begin
        next_state = OPT_IDLE;
      end
      default:
      begin
        next_state = OPT_IDLE;
      end
    endcase
    if (wr_opt)
    begin
      next_sens = wb_dat_i[OPT_SENS_BIT];
      // write-once: a stray later write can never turn the watchdog off
      if (!locked && !MASK_VARIANT)
      begin
        next_watchdog_disable_bit = wb_dat_i[OPT_WDOG_BIT];
        next_locked               = 1'b1;
      end
    end
  end

  always_comb
  begin
    next_irq_q = irq_n_i;
    next_pend  = pend;
    if (irq_ack_i)
    begin
      next_pend = 1'b0;
    end
    // edge set wins over the acknowledge in the same cycle
    if (fall)
    begin
      next_pend = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state                <= OPT_IDLE;
      wb_dat_o             <= OPT_ZERO;
      wb_ack_o             <= 1'b0;
      wb_err_o             <= 1'b0;
      watchdog_disable_bit <= OPT_WDOG_RST;
      sens                 <= OPT_SENS_RST;
      locked               <= 1'b0;
      pend                 <= 1'b0;
      irq_q                <= 1'b1;
    end
    else
    begin
      state                <= next_state;
      wb_dat_o             <= next_dat;
      wb_ack_o             <= next_ack;
      wb_err_o             <= next_err;
      watchdog_disable_bit <= next_watchdog_disable_bit;
      sens                 <= next_sens;
      locked               <= next_locked;
      pend                 <= next_pend;
      irq_q                <= next_irq_q;
    end
  end

  // level mode adds the live low level on top of the latched edge
  assign irq_req_o = pend || (sens && !irq_n_i);
  assign wdog_en_o = MASK_VARIANT ? MASK_WDOG_EN : !watchdog_disable_bit;
  // programmable variant has no halt disable at all
  assign halt_en_o = MASK_VARIANT ? MASK_HALT_EN : 1'b1;

  a_wdog_once: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    locked |=> $stable(watchdog_disable_bit))
    else $error("watchdog bit changed after lock");

  a_wdog_first: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (wr_opt && !locked && !MASK_VARIANT) |=> (watchdog_disable_bit == $past(wb_dat_i[OPT_WDOG_BIT])))
    else $error("first watchdog write lost");

  a_wdog_level: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !MASK_VARIANT |-> (wdog_en_o == !watchdog_disable_bit))
    else $error("watchdog enable polarity wrong");

  a_edge_latch: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ($fell(irq_n_i)) |=> irq_req_o)
    else $error("falling edge not latched");

  a_level_hold: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (sens && !irq_n_i) |-> irq_req_o)
    else $error("level request not held");

  a_edge_only: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (!sens && !pend) |-> !irq_req_o)
    else $error("edge mode request without edge");

  a_halt_on: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !MASK_VARIANT |-> halt_en_o)
    else $error("halt disabled on programmable variant");

  a_mask_fixed: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    MASK_VARIANT |-> (wdog_en_o == MASK_WDOG_EN) && (halt_en_o == MASK_HALT_EN))
    else $error("mask options not fixed");

  a_reset_clear: assert property (@(posedge clk_sys_i)
    $rose(arst_n_i) |-> !watchdog_disable_bit && !sens && !locked)
    else $error("reset values wrong");

  // bus steps: take in idle, then one answer pulse, then quiet
  sequence s_bus_take;
    wb_cyc_i && wb_stb_i && (state == OPT_IDLE);
  endsequence

  sequence s_bus_answer;
    (wb_ack_o ^ wb_err_o) ##1 (!wb_ack_o && !wb_err_o);
  endsequence

  sequence s_first_wr;
    wr_opt && !locked && !MASK_VARIANT;
  endsequence

  a_bus_answer: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_bus_take |=> s_bus_answer)
    else $error("bus answer not a single pulse");

  a_err_unmapped: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (req && !hit(wb_adr_i)) |=> (wb_err_o && !wb_ack_o))
    else $error("unmapped access not refused");

  a_ack_mapped: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (req && hit(wb_adr_i)) |=> (wb_ack_o && !wb_err_o))
    else $error("mapped access not acknowledged");

  a_dat_idle: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !wb_ack_o |-> (wb_dat_o == OPT_ZERO))
    else $error("read data outside ack");

  a_rd_upper: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wb_ack_o |-> ((wb_dat_o >> 4) == OPT_ZERO))
    else $error("upper read bits not zero");

  a_rd_opt: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (req && !wb_we_i && (wb_adr_i == OPT_REG_ADDR))
    |=> (wb_dat_o[OPT_WDOG_BIT] == $past(watchdog_disable_bit))
        && (wb_dat_o[OPT_SENS_BIT] == $past(sens)))
    else $error("option readback wrong");

  a_rd_stat: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (req && !wb_we_i && (wb_adr_i == OPT_STAT_ADDR))
    |=> (wb_dat_o[OPT_STAT_LOCK] == $past(locked))
        && (wb_dat_o[OPT_STAT_MASK] == MASK_VARIANT))
    else $error("status readback wrong");

  a_err_inert: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (req && !hit(wb_adr_i)) |=> ($stable(sens) && $stable(watchdog_disable_bit)))
    else $error("refused access changed a bit");

  a_sel_gate: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (req && wb_we_i && !wb_sel_i[0]) |=> $stable(sens))
    else $error("disabled byte lane wrote");

  a_sens_write: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_opt |=> (sens == $past(wb_dat_i[OPT_SENS_BIT])))
    else $error("sensitivity write lost");

  a_lock_set: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_first_wr |=> locked)
    else $error("first write did not lock");

  a_lock_stay: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    locked |=> locked)
    else $error("lock released without reset");

  a_wdog_hold: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !wr_opt |=> $stable(watchdog_disable_bit))
    else $error("watchdog bit moved without write");

  a_mask_nolock: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    MASK_VARIANT |-> (!locked && !watchdog_disable_bit))
    else $error("mask variant watchdog bit written");

  a_pend_set: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    fall |=> pend)
    else $error("edge latch not set");

  a_pend_clear: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (irq_ack_i && !fall) |=> !pend)
    else $error("edge latch not cleared");

  a_pend_hold: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (pend && !irq_ack_i) |=> pend)
    else $error("edge latch lost");

  a_resp_idle: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (state == OPT_RESP) |=> (state == OPT_IDLE))
    else $error("response state stuck");

  a_state_hot: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $onehot(state))
    else $error("bus state not one-hot");

  a_no_both: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");

endmodule

// ### verif/test_opt_regs.sv
module test_opt_regs
  import opt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic        cyc       = 1'b0;
  logic        stb       = 1'b0;
  logic        we        = 1'b0;
  logic        irq_n     = 1'b1;
  logic        irq_ack   = 1'b0;
  logic [7:0]  adr       = 8'h00;
  logic [3:0]  sel       = 4'hF;
  logic [31:0] dat       = 32'h0000_0000;
  logic [31:0] rd;
  logic [31:0] q;
  logic        ack;
  logic        err;
  logic        e;
  logic        req;
  logic        wen;
  logic        hen;
  logic        m_wen;
  logic        m_hen;
  int          fail_count  = 0;
  int          comparisons = 0;

  opt_regs uut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd),
    .wb_ack_o(ack), .wb_err_o(err), .irq_n_i(irq_n), .irq_ack_i(irq_ack),
    .irq_req_o(req), .wdog_en_o(wen), .halt_en_o(hen));

  // mask variant shares the bus; its options must never move
  opt_regs #(.MASK_VARIANT(1'b1), .MASK_WDOG_EN(1'b0), .MASK_HALT_EN(1'b0)) uut_mask (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(),
    .wb_ack_o(), .wb_err_o(), .irq_n_i(irq_n), .irq_ack_i(irq_ack),
    .irq_req_o(), .wdog_en_o(m_wen), .halt_en_o(m_hen));

  initial
  begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // slave timing is not assumed: wait on ack or err under a bound
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    q = rd;
    e = err;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 20)
    begin
      fail_count++;
      results();
    end
  endtask

  task test_reset();
    bus(1'b0, OPT_REG_ADDR, OPT_ZERO);
    chk(q, 32'h0000_0000);
    chk({31'h0, wen}, 32'h1);
    chk({31'h0, req}, 32'h0);
    chk({31'h0, hen}, 32'h1);
    $display("reset test done");
  endtask

  task test_write_once();
    bus(1'b1, OPT_REG_ADDR, 32'h0000_0003);
    #1 chk({31'h0, wen}, 32'h0);
    chk({31'h0, m_wen}, 32'h0);
    chk({31'h0, m_hen}, 32'h0);
    bus(1'b1, OPT_REG_ADDR, 32'h0000_0000);
    bus(1'b0, OPT_REG_ADDR, OPT_ZERO);
    chk(q, 32'h0000_0002);
    bus(1'b0, OPT_STAT_ADDR, OPT_ZERO);
    chk(q, 32'h0000_0006);
    bus(1'b0, 8'h80, OPT_ZERO);
    chk({31'h0, e}, 32'h1);
    $display("write once test done");
  endtask

  task test_irq();
    @(posedge clk_sys_i) irq_n <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 chk({31'h0, req}, 32'h1);
    @(posedge clk_sys_i) irq_ack <= 1'b1;
    @(posedge clk_sys_i) irq_ack <= 1'b0;
    #1 chk({31'h0, req}, 32'h0);
    bus(1'b1, OPT_REG_ADDR, 32'h0000_0001);
    #1 chk({31'h0, req}, 32'h1);
    @(posedge clk_sys_i) irq_n <= 1'b1;
    @(posedge clk_sys_i);
    #1 chk({31'h0, req}, 32'h0);
    $display("irq test done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    test_reset();
    test_write_once();
    test_irq();
    results();
  end
endmodule
